// ==== include/irq_unit_pkg.sv ====
// Constants and carrier types for the prioritized vectored interrupt unit
package irq_unit_pkg;
    // Register selects on the coprocessor register port
    localparam logic [2:0] SEL_COUNT_CTRL = 3'h0;
    localparam logic [2:0] SEL_EVENT_COUNT = 3'h1;
    localparam logic [2:0] SEL_CAUSE = 3'h2;
    localparam logic [2:0] SEL_IRQ_CTRL = 3'h3;
    localparam logic [2:0] SEL_PRIO_LOW = 3'h4;
    localparam logic [2:0] SEL_PRIO_HIGH = 3'h5;
    // Counter control fields
    localparam int CC_SEL_LSB = 0;
    localparam int CC_KERNEL_BIT = 8;
    localparam int CC_USER_BIT = 9;
    localparam int CC_ENABLE_BIT = 10;
    localparam int COUNT_IRQ_BIT = 31;
    // Cause fields
    localparam int CA_BD_BIT = 31;
    localparam int CA_CE_LSB = 28;
    localparam int CA_W2_BIT = 26;
    localparam int CA_W1_BIT = 25;
    localparam int CA_IV_BIT = 24;
    localparam int CA_IP_LSB = 8;
    localparam int CA_EXC_LSB = 2;
    // Interrupt control fields
    localparam int IC_IM_LSB = 8;
    localparam int IC_TE_BIT = 7;
    localparam int IC_SP_LSB = 0;
    // Line numbers
    localparam int NUM_LINES = 14;
    localparam int NUM_EXT = 10;
    localparam int LEGACY_TIMER_LINE = 7;
    localparam int TIMER_LINE = 12;
    localparam int COUNTER_LINE = 13;
    localparam int EXT_FIVE = 5;
    // Vector arithmetic
    localparam logic [31:0] IRQ_BASE = 32'h0000_0200;
    localparam logic [31:0] LEGACY_OFFSET = 32'h0000_0180;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Core status bits and captured exception facts
    typedef struct packed {
        logic global_irq_allow;
        logic [7:0] line_mask_bits;
    } status_in_t;
    typedef struct packed {
        logic branch_delay_flag;
        logic [1:0] unit;
        logic second_watch_hit;
        logic first_watch_hit;
        logic [4:0] fault_code;
    } exc_info_t;
endpackage

// ==== rtl/irq_unit.sv ====
// Prioritized vectored interrupt unit with performance counter
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Counter control kernel, user, global enables
// - Counter interrupt needs global enable, mask 13
// - Counter uses line 13, timer line 12
// - Ten external interrupt inputs accepted
// - Fourteen lines each with mask and pending
// - Vectoring bit clear gives legacy single vector
// - Control register masks, timer-exclusive, spacing
// - Timer-exclusive steers timer to 12, else to 7 when boot bit clear
// - Boot bit selects timer or input five
// - Boot bit and exclusive make both usable
// - Four-bit priority fields in two registers
// - Priority zero most urgent, all legal
// - Spacing code decode, others reserved
// - Offset plus 0x200 plus exception base
// - Cause register field layout, others zero
// - Any unmasked interrupt ends standby
// - Count bit 31 requests interrupt
// - Five-bit event select, one event
// - Active-low inputs fold into pending bits 11:2
module irq_unit #(
    parameter int NUM_EVENTS = 32,
    parameter logic [31:0] LEGACY_VECTOR = irq_unit_pkg::LEGACY_OFFSET
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [irq_unit_pkg::NUM_EXT-1:0] ext_irq_n,
    input wire logic boot_timer_select,
    input wire logic timer_request,
    input wire irq_unit_pkg::status_in_t core_status,
    input wire logic kernel_mode,
    input wire logic user_mode,
    input wire logic [NUM_EVENTS-1:0] event_hits,
    input wire logic exc_capture,
    input wire irq_unit_pkg::exc_info_t exc_info,
    input wire logic [31:0] exc_base,
    input wire logic in_standby,
    input wire logic [2:0] cp0_sel,
    input wire logic cp0_write,
    input wire logic [31:0] cp0_wdata,
    output logic [31:0] cp0_rdata,
    output logic irq_request,
    output logic [31:0] vector_addr,
    output logic standby_wake
);
    import irq_unit_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Spacing code to byte spacing, reserved codes give zero
    function automatic logic [9:0] spacing_of(input logic [4:0] code);
        case (code)
            5'h00: spacing_of = 10'h000;
            5'h01: spacing_of = 10'h020;
            5'h02: spacing_of = 10'h040;
            5'h04: spacing_of = 10'h080;
            5'h08: spacing_of = 10'h100;
            5'h10: spacing_of = 10'h200;
            default: spacing_of = 10'h000;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] event_sel_reg;
    logic kernel_en_reg;
    logic user_en_reg;
    logic count_en_reg;
    logic [31:0] event_count_reg;
    logic iv_reg;
    logic [1:0] soft_pending_reg;
    exc_info_t exc_reg;
    logic [5:0] high_mask_reg;
    logic te_reg;
    logic [4:0] spacing_reg;
    logic [31:0] prio_low_reg;
    logic [23:0] prio_high_reg;
    logic boot_sel_reg;
    logic [NUM_EXT-1:0] ext_meta_reg;
    logic [NUM_EXT-1:0] ext_sync_reg;

    // External pins pass two flops before use; reset to the idle high level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_meta_reg <= '1;
            ext_sync_reg <= '1;
        end else begin
            ext_meta_reg <= ext_irq_n;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // Boot mode bit caught while reset is held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_sel_reg <= boot_timer_select;
        end
    end

    // Counter control register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            event_sel_reg <= '0;
            kernel_en_reg <= 1'b0;
            user_en_reg <= 1'b0;
            count_en_reg <= 1'b0;
        end else if (cp0_write && cp0_sel == SEL_COUNT_CTRL) begin
            event_sel_reg <= cp0_wdata[CC_SEL_LSB +: 5];
            kernel_en_reg <= cp0_wdata[CC_KERNEL_BIT];
            user_en_reg <= cp0_wdata[CC_USER_BIT];
            count_en_reg <= cp0_wdata[CC_ENABLE_BIT];
        end
    end

    // Event count: one selected event, gated by mode enables
    logic count_step;
    always_comb begin
        count_step = count_en_reg && event_hits[event_sel_reg]
            && ((kernel_mode && kernel_en_reg) || (user_mode && user_en_reg));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            event_count_reg <= RST_ZERO;
        end else if (cp0_write && cp0_sel == SEL_EVENT_COUNT) begin
            event_count_reg <= cp0_wdata;
        end else if (count_step) begin
            event_count_reg <= event_count_reg + 32'h0000_0001;
        end
    end

    // Cause register: software bits, captured exception facts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            iv_reg <= 1'b0;
            soft_pending_reg <= 2'h0;
            exc_reg <= '0;
        end else begin
            if (cp0_write && cp0_sel == SEL_CAUSE) begin
                iv_reg <= cp0_wdata[CA_IV_BIT];
                soft_pending_reg <= cp0_wdata[CA_IP_LSB +: 2];
            end
            if (exc_capture) begin
                exc_reg <= exc_info;
            end
        end
    end

    // Interrupt control and priority registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            high_mask_reg <= '0;
            te_reg <= 1'b0;
            spacing_reg <= '0;
            prio_low_reg <= RST_ZERO;
            prio_high_reg <= '0;
        end else if (cp0_write) begin
            if (cp0_sel == SEL_IRQ_CTRL) begin
                high_mask_reg <= cp0_wdata[IC_IM_LSB +: 6];
                te_reg <= cp0_wdata[IC_TE_BIT];
                spacing_reg <= cp0_wdata[IC_SP_LSB +: 5];
            end
            if (cp0_sel == SEL_PRIO_LOW) begin
                prio_low_reg <= cp0_wdata;
            end
            if (cp0_sel == SEL_PRIO_HIGH) begin
                prio_high_reg <= cp0_wdata[23:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Pending lines and masks
    // ------------------------------------------------------------
    logic [NUM_LINES-1:0] pending;
    logic [NUM_LINES-1:0] mask;
    logic [NUM_LINES-1:0] live;
    logic counter_irq_line;
    logic timer_irq_line;
    logic legacy_timer_line;
    logic [NUM_EXT-1:0] ext_active;

    // Line map: soft 0-1, pins 0-4 on 2-6, pin 5 on 7 with boot bit, pins 6-9 on 8-11
    // Pins are inverted only after the synchroniser
    always_comb begin
        ext_active = ~ext_sync_reg;
        counter_irq_line = event_count_reg[COUNT_IRQ_BIT];
        timer_irq_line = te_reg && timer_request;
        legacy_timer_line = (boot_sel_reg && ext_active[EXT_FIVE])
            || (!boot_sel_reg && !te_reg && timer_request);
        pending = '0;
        pending[1:0] = soft_pending_reg;
        pending[6:2] = ext_active[4:0];
        pending[LEGACY_TIMER_LINE] = legacy_timer_line;
        pending[11:8] = ext_active[9:6];
        pending[TIMER_LINE] = timer_irq_line;
        pending[COUNTER_LINE] = counter_irq_line;
        mask = {high_mask_reg, core_status.line_mask_bits};
        live = pending & mask;
    end

    // ------------------------------------------------------------
    // Priority resolution and vector
    // ------------------------------------------------------------
    logic [3:0] win_prio;
    logic any_live;
    logic [55:0] prio_all;

    // Lowest value wins; scanning upward with <= hands ties to higher line
    always_comb begin
        prio_all = {prio_high_reg, prio_low_reg};
        win_prio = 4'hF;
        any_live = 1'b0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (live[i] && (!any_live || prio_all[4*i +: 4] <= win_prio)) begin
                win_prio = prio_all[4*i +: 4];
                any_live = 1'b1;
            end
        end
    end

    logic [31:0] vector_offset;
    logic [31:0] vector_next;
    logic irq_next;

    always_comb begin
        vector_offset = {18'h0, 14'(win_prio * spacing_of(spacing_reg))};
        if (iv_reg) begin
            vector_next = exc_base + IRQ_BASE + vector_offset;
        end else begin
            vector_next = exc_base + LEGACY_VECTOR;
        end
        irq_next = core_status.global_irq_allow && any_live;
    end

    // Outputs to the core
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_request <= 1'b0;
            vector_addr <= RST_ZERO;
            standby_wake <= 1'b0;
        end else begin
            irq_request <= irq_next;
            vector_addr <= vector_next;
            standby_wake <= in_standby && any_live;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    logic [31:0] read_next;
    always_comb begin
        read_next = RST_ZERO;
        case (cp0_sel)
            SEL_COUNT_CTRL: begin
                read_next[CC_SEL_LSB +: 5] = event_sel_reg;
                read_next[CC_KERNEL_BIT] = kernel_en_reg;
                read_next[CC_USER_BIT] = user_en_reg;
                read_next[CC_ENABLE_BIT] = count_en_reg;
            end
            SEL_EVENT_COUNT: read_next = event_count_reg;
            SEL_CAUSE: begin
                read_next[CA_BD_BIT] = exc_reg.branch_delay_flag;
                read_next[CA_CE_LSB +: 2] = exc_reg.unit;
                read_next[CA_W2_BIT] = exc_reg.second_watch_hit;
                read_next[CA_W1_BIT] = exc_reg.first_watch_hit;
                read_next[CA_IV_BIT] = iv_reg;
                read_next[CA_IP_LSB +: NUM_LINES] = pending;
                read_next[CA_EXC_LSB +: 5] = exc_reg.fault_code;
            end
            SEL_IRQ_CTRL: begin
                read_next[IC_IM_LSB +: 6] = high_mask_reg;
                read_next[IC_TE_BIT] = te_reg;
                read_next[IC_SP_LSB +: 5] = spacing_reg;
            end
            SEL_PRIO_LOW: read_next = prio_low_reg;
            SEL_PRIO_HIGH: read_next = {8'h00, prio_high_reg};
            default: read_next = RST_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cp0_rdata <= RST_ZERO;
        end else begin
            cp0_rdata <= read_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence ctr_armed_s;
        event_count_reg[COUNT_IRQ_BIT] && high_mask_reg[5] && core_status.global_irq_allow;
    endsequence
    sequence ctr_stalled_s;
        !count_step && !(cp0_write && cp0_sel == SEL_EVENT_COUNT);
    endsequence

    ctr_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctr_armed_s |=> irq_request)
        else $error("counter overflow did not raise request");
    ctr_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctr_stalled_s |=> $stable(event_count_reg))
        else $error("event count moved without enable");
    ctr_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        count_step && !cp0_write |=> event_count_reg == $past(event_count_reg) + 32'h1)
        else $error("event count missed a step");
    req_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        !core_status.global_irq_allow |=> !irq_request)
        else $error("request raised with interrupts disabled");
    te_route_a: assert property (@(posedge sys_clk) disable iff (rst)
        te_reg && timer_request |-> pending[TIMER_LINE] && !(pending[7] && !boot_sel_reg))
        else $error("timer not steered to line twelve");
    boot_route_a: assert property (@(posedge sys_clk) disable iff (rst)
        boot_sel_reg && ext_active[EXT_FIVE] |-> pending[LEGACY_TIMER_LINE])
        else $error("input five not on line seven");
    legacy_vec_a: assert property (@(posedge sys_clk) disable iff (rst)
        !iv_reg ##1 !$past(iv_reg) |-> vector_addr == $past(exc_base) + LEGACY_VECTOR)
        else $error("legacy vector wrong");
    wake_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_standby && |live |=> standby_wake)
        else $error("standby not ended by interrupt");
    ctrl_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(cp0_sel) == SEL_IRQ_CTRL |-> cp0_rdata[31:16] == 16'h0 && cp0_rdata[6:5] == 2'h0)
        else $error("reserved control bits not zero");
    prio_max_a: assert property (@(posedge sys_clk) disable iff (rst)
        iv_reg && spacing_reg == 5'h01 && irq_next
        |=> vector_addr <= $past(exc_base) + IRQ_BASE + 32'h1E0)
        else $error("vector offset out of range");
endmodule
`default_nettype wire

// ==== verif/core_model.sv ====
// Core side model: status bits and exception capture
`timescale 1ns/1ns
`default_nettype none
module core_model
    import irq_unit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic irq_request,
    input wire logic ie_req,
    input wire logic [7:0] mask_req,
    input wire logic take_req,
    input wire irq_unit_pkg::exc_info_t info_req,
    output var irq_unit_pkg::status_in_t core_status,
    output logic exc_capture,
    output var irq_unit_pkg::exc_info_t exc_info
);
    import irq_unit_pkg::*;
    // Status follows the bench; taking an interrupt drops the global enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_status <= '0;
        end else begin
            core_status.line_mask_bits <= mask_req;
            core_status.global_irq_allow <= ie_req && !(take_req && irq_request);
        end
    end
    // One-cycle capture pulse with the facts of the exception taken
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            exc_capture <= 1'b0;
            exc_info <= '0;
        end else begin
            exc_capture <= take_req;
            exc_info <= info_req;
        end
    end
endmodule
`default_nettype wire

// ==== verif/irq_unit_tb_top.sv ====
// Self-checking bench for the prioritized vectored interrupt unit
`timescale 1ns/1ns
`default_nettype none
module irq_unit_tb_top;
    import irq_unit_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] ext_irq_n = 10'h3FF;
    logic boot_timer_select = 1'b0;
    logic timer_request = 1'b0;
    logic kernel_mode = 1'b0;
    logic user_mode = 1'b0;
    logic [31:0] event_hits = 32'h0;
    logic [31:0] exc_base = 32'h8000_0000;
    logic in_standby = 1'b0;
    logic [2:0] cp0_sel = 3'h0;
    logic cp0_write = 1'b0;
    logic [31:0] cp0_wdata = 32'h0;
    logic ie_req = 1'b0;
    logic [7:0] mask_req = 8'h00;
    logic take_req = 1'b0;
    exc_info_t info_req = '0;
    status_in_t core_status;
    exc_info_t exc_info;
    logic exc_capture, irq_request, standby_wake;
    logic [31:0] cp0_rdata, vector_addr;
    int errors = 0;
    int checks_done = 0;
    // Clock at 100 MHz
    always #5 sys_clk = ~sys_clk;
    irq_unit i_irq_unit (.sys_clk, .rst, .ext_irq_n, .boot_timer_select, .timer_request,
        .core_status, .kernel_mode, .user_mode, .event_hits, .exc_capture, .exc_info,
        .exc_base, .in_standby, .cp0_sel, .cp0_write, .cp0_wdata, .cp0_rdata,
        .irq_request, .vector_addr, .standby_wake);
    core_model i_core_model (.sys_clk, .rst, .irq_request, .ie_req, .mask_req, .take_req,
        .info_req, .core_status, .exc_capture, .exc_info);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        cp0_sel <= s;
        cp0_write <= 1'b1;
        cp0_wdata <= d;
        @(posedge sys_clk);
        cp0_write <= 1'b0;
    endtask
    // Read answers one edge after the select is taken
    task automatic rd_chk(input string what, input logic [2:0] s, input logic [31:0] exp);
        @(posedge sys_clk);
        cp0_sel <= s;
        @(posedge sys_clk);
        #1;
        chk(what, exp, cp0_rdata);
    endtask
    // Covers pin sync, status model delay and the registered outputs
    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    task automatic run_events(input logic k, input logic u, input int n);
        @(posedge sys_clk);
        kernel_mode <= k;
        user_mode <= u;
        event_hits <= 32'h0000_0018;
        repeat (n) @(posedge sys_clk);
        event_hits <= 32'h0000_0010;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int s = 0; s < 8; s++) rd_chk("reset value", 3'(s), 32'h0);
        wr(SEL_COUNT_CTRL, 32'hFFFF_FFFF);
        rd_chk("count ctrl", SEL_COUNT_CTRL, 32'h0000_071F);
        wr(SEL_IRQ_CTRL, 32'hFFFF_FFFF);
        rd_chk("irq ctrl", SEL_IRQ_CTRL, 32'h0000_3F9F);
        wr(SEL_PRIO_HIGH, 32'hFFFF_FFFF);
        rd_chk("prio high", SEL_PRIO_HIGH, 32'h00FF_FFFF);
        wr(SEL_PRIO_LOW, 32'hFFFF_FFFF);
        rd_chk("prio low", SEL_PRIO_LOW, 32'hFFFF_FFFF);
        wr(SEL_CAUSE, 32'hFFFF_FFFF);
        rd_chk("cause", SEL_CAUSE, 32'h0100_0300);
        wr(3'h6, 32'hFFFF_FFFF);
        rd_chk("unmapped", 3'h6, 32'h0);
        wr(SEL_CAUSE, 32'h0);
        $display("register test done");
    endtask
    task automatic t_counter();
        wr(SEL_COUNT_CTRL, 32'h0000_0503);
        run_events(1'b1, 1'b0, 10);
        rd_chk("kernel count", SEL_EVENT_COUNT, 32'h0000_000A);
        run_events(1'b0, 1'b1, 5);
        rd_chk("user off", SEL_EVENT_COUNT, 32'h0000_000A);
        wr(SEL_COUNT_CTRL, 32'h0000_0603);
        run_events(1'b0, 1'b1, 5);
        rd_chk("user count", SEL_EVENT_COUNT, 32'h0000_000F);
        wr(SEL_COUNT_CTRL, 32'h0000_0103);
        run_events(1'b1, 1'b0, 4);
        rd_chk("global off", SEL_EVENT_COUNT, 32'h0000_000F);
        wr(SEL_COUNT_CTRL, 32'h0);
        wr(SEL_EVENT_COUNT, 32'h8000_0000);
        wr(SEL_IRQ_CTRL, 32'h0000_2000);
        settle();
        rd_chk("count pending", SEL_CAUSE, 32'h0020_0000);
        chk_bit("no enable", 1'b0, irq_request);
        @(posedge sys_clk);
        ie_req <= 1'b1;
        settle();
        chk_bit("count irq", 1'b1, irq_request);
        wr(SEL_IRQ_CTRL, 32'h0);
        settle();
        chk_bit("masked", 1'b0, irq_request);
        wr(SEL_EVENT_COUNT, 32'h0);
        $display("counter test done");
    endtask
    task automatic t_timer();
        @(posedge sys_clk);
        mask_req <= 8'h80;
        timer_request <= 1'b1;
        wr(SEL_IRQ_CTRL, 32'h0000_1000);
        settle();
        rd_chk("timer on 7", SEL_CAUSE, 32'h0000_8000);
        chk_bit("timer irq", 1'b1, irq_request);
        wr(SEL_IRQ_CTRL, 32'h0000_1080);
        @(posedge sys_clk);
        ext_irq_n <= 10'h3DF;
        settle();
        rd_chk("timer on 12", SEL_CAUSE, 32'h0010_0000);
        @(posedge sys_clk);
        timer_request <= 1'b0;
        ext_irq_n <= 10'h3FF;
        $display("timer test done");
    endtask
    task automatic t_vector();
        logic [4:0] code [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03};
        logic [31:0] sp [7] = '{32'h0, 32'h20, 32'h40, 32'h80, 32'h100, 32'h200, 32'h0};
        logic [31:0] pw [4] = '{32'h29, 32'h0F, 32'h66, 32'h29};
        logic [31:0] pe [4] = '{32'h2, 32'h0, 32'h6, 32'h9};
        logic [31:0] exp_vec;
        @(posedge sys_clk);
        mask_req <= 8'h03;
        wr(SEL_CAUSE, 32'h0100_0100);
        for (int i = 0; i < 7; i++) begin
            wr(SEL_PRIO_LOW, 32'(2 * i + 1));
            wr(SEL_IRQ_CTRL, {27'h0, code[i]});
            settle();
            exp_vec = exc_base + IRQ_BASE + 32'(2 * i + 1) * sp[i];
            chk("vector", exp_vec, vector_addr);
        end
        wr(SEL_IRQ_CTRL, 32'h0000_0001);
        wr(SEL_CAUSE, 32'h0100_0300);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            mask_req <= (i == 3) ? 8'h01 : 8'h03;
            wr(SEL_PRIO_LOW, pw[i]);
            settle();
            chk("winner", exc_base + IRQ_BASE + 32'h20 * pe[i], vector_addr);
        end
        wr(SEL_CAUSE, 32'h0000_0100);
        settle();
        chk("legacy", exc_base + LEGACY_OFFSET, vector_addr);
        @(posedge sys_clk);
        ie_req <= 1'b0;
        mask_req <= 8'h00;
        in_standby <= 1'b1;
        settle();
        chk_bit("wake masked", 1'b0, standby_wake);
        @(posedge sys_clk);
        mask_req <= 8'h01;
        settle();
        chk_bit("wake", 1'b1, standby_wake);
        chk_bit("irq no enable", 1'b0, irq_request);
        @(posedge sys_clk);
        in_standby <= 1'b0;
        wr(SEL_CAUSE, 32'h0);
        $display("vector test done");
    endtask
    task automatic t_pins();
        @(posedge sys_clk);
        mask_req <= 8'hFF;
        wr(SEL_IRQ_CTRL, 32'h0000_0F80);
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            ext_irq_n <= ~(10'h001 << i);
            settle();
            rd_chk("pin line", SEL_CAUSE, 32'h0000_0400 << i);
        end
        @(posedge sys_clk);
        ext_irq_n <= 10'h3DF;
        timer_request <= 1'b1;
        settle();
        rd_chk("both usable", SEL_CAUSE, 32'h0010_8000);
        @(posedge sys_clk);
        ext_irq_n <= 10'h3FF;
        timer_request <= 1'b0;
        @(posedge sys_clk);
        info_req <= '{1'b1, 2'b10, 1'b1, 1'b0, 5'h1D};
        take_req <= 1'b1;
        @(posedge sys_clk);
        take_req <= 1'b0;
        settle();
        rd_chk("cause fields", SEL_CAUSE, 32'hA400_0074);
        $display("pin and cause test done");
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_counter();
        t_timer();
        t_vector();
        @(posedge sys_clk);
        rst <= 1'b1;
        boot_timer_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_pins();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
`default_nettype wire
